// file: design/spzu_pkg.sv
// constants, register map and carrier types of serial port zero
package spzu_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0]  IDX_POWER   = 8'h87;  // power_control
  localparam logic [7:0]  IDX_CTRL    = 8'h98;  // serial_control
  localparam logic [7:0]  IDX_BUF     = 8'h99;  // serial_buffer
  localparam logic [7:0]  IDX_BAUD    = 8'ha0;  // baud source select
  localparam logic [7:0]  IDX_ISTAT   = 8'ha1;  // interrupt status, write one to clear
  localparam logic [7:0]  IDX_IMASK   = 8'ha2;  // interrupt mask
  localparam int unsigned IDX_W       = 10;     // index bits decoded from haddr[11:2]

  // field positions
  localparam int unsigned POWER_DOUBLE_BIT = 7;  // double_rate_bit
  localparam int unsigned BAUD_BD_BIT      = 0;  // baud_prescaler_select

  // reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic        DOUBLE_RESET = 1'b0;
  localparam logic        BD_RESET    = 1'b0;
  localparam logic [1:0]  IRQ_RESET   = 2'h0;

  // rates, relative to the oscillator clock clk except the timer 1 overflow counts
  localparam int unsigned OSC_HZ        = 200_000_000;
  localparam int unsigned MODE0_DIV     = 12;     // shift mode bit = 12 clocks
  localparam int unsigned OVERSAMPLE    = 16;     // uart modes run 16 ticks per bit
  localparam int unsigned MODE2_DIV_FAST = 32;
  localparam int unsigned MODE2_DIV_SLOW = 64;
  localparam int unsigned BD_BAUD_LOW   = 4800;
  localparam int unsigned BD_BAUD_HIGH  = 9600;
  localparam int unsigned T1_OVF_FAST   = 1;      // overflows per tick, double rate
  localparam int unsigned T1_OVF_SLOW   = 2;      // overflows per tick, single rate

  // divider limits derived from the rates above
  localparam int unsigned DIV_W       = 12;
  localparam logic [DIV_W-1:0] LIM_HALF0 = DIV_W'(MODE0_DIV / 2);
  localparam logic [DIV_W-1:0] LIM_M2_FAST = DIV_W'(MODE2_DIV_FAST / OVERSAMPLE);
  localparam logic [DIV_W-1:0] LIM_M2_SLOW = DIV_W'(MODE2_DIV_SLOW / OVERSAMPLE);
  localparam logic [DIV_W-1:0] LIM_BD_LOW  = DIV_W'(OSC_HZ / (BD_BAUD_LOW * OVERSAMPLE));
  localparam logic [DIV_W-1:0] LIM_BD_HIGH = DIV_W'(OSC_HZ / (BD_BAUD_HIGH * OVERSAMPLE));
  localparam logic [DIV_W-1:0] LIM_T1_FAST = DIV_W'(T1_OVF_FAST);
  localparam logic [DIV_W-1:0] LIM_T1_SLOW = DIV_W'(T1_OVF_SLOW);

  // frame counters
  localparam logic [3:0]  FRAME8_LAST = 4'h9;  // start, 8 data, stop
  localparam logic [3:0]  FRAME9_LAST = 4'ha;  // start, 8 data, ninth, stop
  localparam logic [3:0]  SHIFT0_LAST = 4'h7;  // 8 bits in shift mode
  localparam logic [3:0]  SUB_MID     = 4'h7;  // sample point inside a bit
  localparam logic [3:0]  SUB_LAST    = 4'hf;  // last tick of a bit

  // operating modes as coded by mode_select_high:mode_select_low
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_UART8,
    MODE_UART9_FIXED,
    MODE_UART9_VAR
  } spzu_mode_e;

  // serial_control layout, msb first
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiprocessor_enable;
    logic receive_enable_bit;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
  } spzu_ctrl_s;

  // interrupt status and mask layout
  typedef struct packed {
    logic rx;
    logic tx;
  } spzu_irq_s;

endpackage

// file: design/spzu_tick_div.sv
// enable-pulse divider: one tick per limit enables
`timescale 1ns/10ps
`default_nettype none
module spzu_tick_div #(
  parameter int unsigned W = 12  // counter width
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         en,     // counted event
  input  wire logic [W-1:0] limit,  // events per tick, at least one
  output logic              tick    // one-cycle pulse
);
  // refuse counters too narrow to be useful
  if (W < 2) begin : g_w_check
    $error("spzu_tick_div: W must be at least 2");
  end

  logic [W-1:0] cnt_q;  // events seen since last tick
  logic         wrap;   // this event completes a tick

  assign wrap = en && (cnt_q >= W'(limit - W'(1)));

  // count events, restart on wrap; a shrunk limit wraps at the next event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (wrap) begin
      cnt_q <= '0;
    end else if (en) begin
      cnt_q <= W'(cnt_q + W'(1));
    end
  end

  assign tick = wrap;
endmodule
`default_nettype wire

// file: design/spzu_top.sv
// serial port zero: four-mode serial interface behind an ahb-lite slave
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module spzu_top
  import spzu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        timer1_overflow,   // one-cycle pulse from timer 1
  input  wire logic        serial_in_pin_i,   // receive pin level
  output logic             serial_in_pin_o,   // receive pin drive in shift mode
  output logic             serial_in_pin_oe,  // high while driving receive pin
  output logic             serial_out_pin,    // transmit data or shift clock
  output logic             irq                // level interrupt
);
  typedef enum logic {TX_IDLE, TX_BUSY} spzu_tx_e;
  typedef enum logic {RX_IDLE, RX_BUSY} spzu_rx_e;

  // ---------------- bus slave ----------------
  logic             wr_pend_q;   // write data phase
  logic             rd_pend_q;   // read wait cycle
  logic [IDX_W-1:0] idx_q;       // latched register index
  logic [31:0]      hrdata_q;    // read data
  logic             addr_ok;
  logic             sel_ctrl, sel_buf, sel_power, sel_baud, sel_istat, sel_imask;
  logic             wr_ctrl, wr_buf, wr_power, wr_baud, wr_istat, wr_imask;
  logic [31:0]      rd_mux;
  logic             size_ok;     // size not checked; every transfer size changes state

  assign addr_ok   = hsel && htrans[1] && hready;
  assign size_ok   = 1'b1;
  assign sel_ctrl  = idx_q == IDX_W'(IDX_CTRL);
  assign sel_buf   = idx_q == IDX_W'(IDX_BUF);
  assign sel_power = idx_q == IDX_W'(IDX_POWER);
  assign sel_baud  = idx_q == IDX_W'(IDX_BAUD);
  assign sel_istat = idx_q == IDX_W'(IDX_ISTAT);
  assign sel_imask = idx_q == IDX_W'(IDX_IMASK);
  assign wr_ctrl   = wr_pend_q && sel_ctrl && size_ok;
  assign wr_buf    = wr_pend_q && sel_buf && size_ok;
  assign wr_power  = wr_pend_q && sel_power && size_ok;
  assign wr_baud   = wr_pend_q && sel_baud && size_ok;
  assign wr_istat  = wr_pend_q && sel_istat && size_ok;
  assign wr_imask  = wr_pend_q && sel_imask && size_ok;

  // latch address phase; reads take one wait cycle, writes none
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= '0;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      rd_pend_q <= addr_ok && !hwrite;
      if (addr_ok) begin
        idx_q <= haddr[IDX_W+1:2];
      end
    end
  end

  // ---------------- registers ----------------
  spzu_ctrl_s ctrl_q, ctrl_d;     // serial_control
  logic       double_rate_bit_q;             // double_rate_bit
  logic       bd_q;               // baud_prescaler_select
  spzu_irq_s  istat_q, istat_d;   // sticky events
  spzu_irq_s  imask_q, imask_d;
  logic [7:0] rxbuf_q;            // receive register behind serial_buffer
  logic       irq_q;
  logic       ti_set, ri_set;     // hardware flag events
  logic       rx_accept, rx_bit8, rx_uart_acc;
  logic [7:0] rx_data;

  // reads: serial_buffer returns the receive register only
  assign rd_mux = sel_ctrl  ? {24'h0, ctrl_q} :
                  sel_buf   ? {24'h0, rxbuf_q} :
                  sel_power ? {24'h0, double_rate_bit_q, 7'h0} :
                  sel_baud  ? {31'h0, bd_q} :
                  sel_istat ? {30'h0, istat_q} :
                  sel_imask ? {30'h0, imask_q} : 32'h0;

  // flag next values: hardware set wins over a software write
  always_comb begin
    ctrl_d = wr_ctrl ? spzu_ctrl_s'(hwdata[7:0]) : ctrl_q;
    if (ti_set) begin
      ctrl_d.transmit_done_flag = 1'b1;
    end
    if (ri_set) begin
      ctrl_d.receive_done_flag = 1'b1;
    end
    if (rx_uart_acc) begin
      ctrl_d.received_ninth_bit = rx_bit8;
    end
    istat_d = wr_istat ? (istat_q & ~spzu_irq_s'(hwdata[1:0])) : istat_q;
    istat_d.tx = istat_d.tx | ti_set;
    istat_d.rx = istat_d.rx | ri_set;
    imask_d = wr_imask ? spzu_irq_s'(hwdata[1:0]) : imask_q;
  end

  // register storage, read data and interrupt level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= spzu_ctrl_s'(CTRL_RESET);
      double_rate_bit_q   <= DOUBLE_RESET;
      bd_q     <= BD_RESET;
      istat_q  <= spzu_irq_s'(IRQ_RESET);
      imask_q  <= spzu_irq_s'(IRQ_RESET);
      rxbuf_q  <= 8'h00;
      hrdata_q <= 32'h0;
      irq_q    <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      irq_q   <= |(istat_d & imask_d);
      if (wr_power) begin
        double_rate_bit_q <= hwdata[POWER_DOUBLE_BIT];
      end
      if (wr_baud) begin
        bd_q <= hwdata[BAUD_BD_BIT];
      end
      if (rx_accept) begin
        rxbuf_q <= rx_data;
      end
      if (rd_pend_q) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  assign hreadyout = !rd_pend_q;
  assign hrdata    = hrdata_q;
  assign hresp     = 1'b0;
  assign irq       = irq_q;

  // ---------------- mode and rate ----------------
  spzu_mode_e mode;
  logic       mode0, nine;
  logic [3:0] frame_last;
  logic       tick_half, tick_m2, tick_t1, tick_bd, tick16;

  assign mode       = spzu_mode_e'({ctrl_q.mode_select_high, ctrl_q.mode_select_low});
  assign mode0      = mode == MODE_SHIFT;
  assign nine       = (mode == MODE_UART9_FIXED) || (mode == MODE_UART9_VAR);
  assign frame_last = nine ? FRAME9_LAST : FRAME8_LAST;

  // half bit of shift mode, fixed six clocks
  spzu_tick_div #(.W(DIV_W)) u_div_half (
    .clk   (clk),
    .rst   (rst),
    .en    (1'b1),
    .limit (LIM_HALF0),
    .tick  (tick_half)
  );

  // fixed 9-bit rate, double_rate_bit picks /32 over /64
  spzu_tick_div #(.W(DIV_W)) u_div_m2 (
    .clk   (clk),
    .rst   (rst),
    .en    (1'b1),
    .limit (double_rate_bit_q ? LIM_M2_FAST : LIM_M2_SLOW),
    .tick  (tick_m2)
  );

  // timer overflows, whatever timer mode produced them
  spzu_tick_div #(.W(DIV_W)) u_div_t1 (
    .clk   (clk),
    .rst   (rst),
    .en    (timer1_overflow),
    .limit (double_rate_bit_q ? LIM_T1_FAST : LIM_T1_SLOW),
    .tick  (tick_t1)
  );

  // dedicated prescaler, 9600 with double rate else 4800
  spzu_tick_div #(.W(DIV_W)) u_div_bd (
    .clk   (clk),
    .rst   (rst),
    .en    (1'b1),
    .limit (double_rate_bit_q ? LIM_BD_HIGH : LIM_BD_LOW),
    .tick  (tick_bd)
  );

  // oversample tick: modes 1 and 3 share the variable source
  assign tick16 = (mode == MODE_UART9_FIXED) ? tick_m2 :
                  bd_q ? tick_bd : tick_t1;

  // ---------------- transmitter ----------------
  spzu_tx_e    tx_st_q;
  logic [10:0] tx_sh_q;   // frame, lsb goes out first
  logic [3:0]  tx_bit_q;  // bit index in frame
  logic [3:0]  tx_sub_q;  // oversample tick within bit
  logic        tx_ph_q;   // shift mode: 0 clock low, 1 clock high
  logic        tx_busy;

  assign tx_busy = tx_st_q == TX_BUSY;
  assign ti_set  = tx_busy && ((mode0 && tick_half && tx_ph_q && tx_bit_q == SHIFT0_LAST) ||
                   (!mode0 && tick16 && tx_sub_q == SUB_LAST &&
                    4'(tx_bit_q + 4'h1) == frame_last));

  // load on buffer write, then shift at the mode's rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_q  <= TX_IDLE;
      tx_sh_q  <= '1;
      tx_bit_q <= 4'h0;
      tx_sub_q <= 4'h0;
      tx_ph_q  <= 1'b0;
    end else if (wr_buf) begin
      tx_st_q  <= TX_BUSY;
      tx_bit_q <= 4'h0;
      tx_sub_q <= 4'h0;
      tx_ph_q  <= 1'b0;
      if (mode0) begin
        tx_sh_q <= {3'b111, hwdata[7:0]};
      end else if (nine) begin
        tx_sh_q <= {1'b1, ctrl_q.transmit_ninth_bit, hwdata[7:0], 1'b0};
      end else begin
        tx_sh_q <= {2'b11, hwdata[7:0], 1'b0};
      end
    end else if (tx_busy && mode0 && tick_half) begin
      tx_ph_q <= !tx_ph_q;
      if (tx_ph_q) begin
        // end of bit: next data bit, or done after eight
        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
        tx_bit_q <= 4'(tx_bit_q + 4'h1);
        if (tx_bit_q == SHIFT0_LAST) begin
          tx_st_q <= TX_IDLE;
        end
      end
    end else if (tx_busy && !mode0 && tick16) begin
      tx_sub_q <= 4'(tx_sub_q + 4'h1);
      if (tx_sub_q == SUB_LAST) begin
        if (tx_bit_q == frame_last) begin
          tx_st_q <= TX_IDLE;
        end else begin
          tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
          tx_bit_q <= 4'(tx_bit_q + 4'h1);
        end
      end
    end
  end

  // ---------------- receiver ----------------
  spzu_rx_e   rx_st_q;
  logic       rx_m_q, rx_s_q, rx_prev_q;  // pin synchroniser and edge history
  logic [9:0] rx_sh_q;
  logic [9:0] rx_full;
  logic [3:0] rx_bit_q, rx_sub_q;
  logic       rx_ph_q;
  logic       rx_busy, start_u, start_0, samp_u, end_u, end_0, false_start;

  assign rx_busy     = rx_st_q == RX_BUSY;
  assign start_u     = !rx_busy && !mode0 && ctrl_q.receive_enable_bit &&
                       rx_prev_q && !rx_s_q;
  assign start_0     = !rx_busy && mode0 && ctrl_q.receive_enable_bit &&
                       !ctrl_q.receive_done_flag && !tx_busy && !wr_buf && tick_half;
  assign samp_u      = rx_busy && !mode0 && tick16 && rx_sub_q == SUB_MID;
  assign false_start = samp_u && rx_bit_q == 4'h0 && rx_s_q;
  assign end_u       = samp_u && rx_bit_q == frame_last;
  assign end_0       = rx_busy && mode0 && tick_half && rx_ph_q && rx_bit_q == SHIFT0_LAST;
  assign rx_full     = {rx_s_q, rx_sh_q[9:1]};
  // 9-bit: ninth then ignored stop; 8-bit: stop lands in ninth flag
  assign rx_data     = mode0 ? rx_sh_q[7:0] : nine ? rx_full[7:0] : rx_full[8:1];
  assign rx_bit8     = nine ? rx_full[8] : rx_full[9];
  assign rx_uart_acc = end_u && !ctrl_q.receive_done_flag &&
                       (!ctrl_q.multiprocessor_enable || rx_bit8);
  assign rx_accept   = rx_uart_acc || end_0;
  assign ri_set      = rx_accept;

  // receive framing; shift mode start waits for an idle transmitter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_m_q    <= 1'b1;
      rx_s_q    <= 1'b1;
      rx_prev_q <= 1'b1;
      rx_st_q   <= RX_IDLE;
      rx_sh_q   <= '0;
      rx_bit_q  <= 4'h0;
      rx_sub_q  <= 4'h0;
      rx_ph_q   <= 1'b0;
    end else begin
      rx_m_q    <= serial_in_pin_i;
      rx_s_q    <= rx_m_q;
      rx_prev_q <= rx_s_q;
      if (start_u || start_0) begin
        rx_st_q  <= RX_BUSY;
        rx_bit_q <= 4'h0;
        rx_sub_q <= 4'h0;
        rx_ph_q  <= 1'b0;
        rx_sh_q  <= '0;
      end else if (rx_busy && mode0 && tick_half) begin
        rx_ph_q <= !rx_ph_q;
        if (!rx_ph_q) begin
          rx_sh_q <= {2'b00, rx_s_q, rx_sh_q[7:1]};  // sample at clock rise
        end else begin
          rx_bit_q <= 4'(rx_bit_q + 4'h1);
          if (rx_bit_q == SHIFT0_LAST) begin
            rx_st_q <= RX_IDLE;
          end
        end
      end else if (rx_busy && !mode0 && tick16) begin
        rx_sub_q <= 4'(rx_sub_q + 4'h1);
        if (samp_u) begin
          if (false_start || end_u) begin
            rx_st_q <= RX_IDLE;  // glitch rejected or frame complete
          end else begin
            rx_bit_q <= 4'(rx_bit_q + 4'h1);
            if (rx_bit_q != 4'h0) begin
              rx_sh_q <= rx_full;
            end
          end
        end
      end
    end
  end

  // ---------------- pins ----------------
  logic out_q, in_o_q, in_oe_q, out_d;

  // shift mode: clock low in first half of each bit, idles high
  assign out_d = mode0 ? !((tx_busy && !tx_ph_q) || (rx_busy && !rx_ph_q)) :
                 tx_busy ? tx_sh_q[0] : 1'b1;

  // registered pin drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q   <= 1'b1;
      in_o_q  <= 1'b1;
      in_oe_q <= 1'b0;
    end else begin
      out_q   <= out_d;
      in_o_q  <= tx_sh_q[0];
      in_oe_q <= tx_busy && mode0;
    end
  end

  assign serial_out_pin   = out_q;
  assign serial_in_pin_o  = in_o_q;
  assign serial_in_pin_oe = in_oe_q;

  // ---------------- checks ----------------
  a_tx_start_low: assert property (@(posedge clk) disable iff (rst)
    (wr_buf && !mode0 && !wr_ctrl) |-> ##2 (serial_out_pin == 1'b0))
    else $error("start bit not driven after buffer write");
  a_ti_stop_high: assert property (@(posedge clk) disable iff (rst)
    (ti_set && !mode0 && !wr_buf && !wr_ctrl) |-> ##2 (serial_out_pin == 1'b1))
    else $error("transmit flag not at stop bit");
  a_ti_sticky: assert property (@(posedge clk) disable iff (rst)
    (ctrl_q.transmit_done_flag && !wr_ctrl) |=> ctrl_q.transmit_done_flag)
    else $error("transmit flag cleared by hardware");
  a_half_period: assert property (@(posedge clk) disable iff (rst)
    tick_half |=> (!tick_half)[*5] ##1 tick_half)
    else $error("shift mode half bit not six clocks");
  a_m2_fast_rate: assert property (@(posedge clk) disable iff (rst)
    (tick_m2 && double_rate_bit_q && !wr_power) ##1 !wr_power |-> !tick_m2 ##1 tick_m2)
    else $error("fixed rate not clk/32 with double rate");
  a_mp_block: assert property (@(posedge clk) disable iff (rst)
    (end_u && ctrl_q.multiprocessor_enable && !rx_bit8 && !ctrl_q.receive_done_flag
     && !wr_ctrl) |=> !ctrl_q.receive_done_flag)
    else $error("receive flag raised for unaddressed frame");
  a_ninth_load: assert property (@(posedge clk) disable iff (rst)
    (rx_uart_acc && !wr_ctrl) |=> (ctrl_q.received_ninth_bit == $past(rx_bit8)))
    else $error("received ninth bit not stored");
  a_rxbuf_apart: assert property (@(posedge clk) disable iff (rst)
    (wr_buf && !rx_accept) |=> $stable(rxbuf_q))
    else $error("buffer write changed receive register");
  a_tx_ninth: assert property (@(posedge clk) disable iff (rst)
    (wr_buf && nine) |=> (tx_sh_q[9] == $past(ctrl_q.transmit_ninth_bit)))
    else $error("ninth bit not taken from control");
  a_shift_drive: assert property (@(posedge clk) disable iff (rst)
    (tx_busy && mode0) |=> serial_in_pin_oe)
    else $error("shift mode data pin not driven");
endmodule
`default_nettype wire

// file: sim/spzu_remote.sv
// remote serial device model on the far side of serial port zero
`timescale 1ns/10ps
`default_nettype none
module spzu_remote (
  input  wire logic clk,         // oscillator clock
  input  wire logic tx_line,     // transmit pin or shift clock from the block
  input  wire logic shift_data,  // receive pin as driven by the block
  output logic      rx_line      // line into the block
);
  initial rx_line = 1'b1;  // idle high outside frames
  // send nb bits lsb first, bt clocks each, then idle high
  task automatic send(input logic [10:0] f, input int nb, input int bt);
    for (int i = 0; i < nb; i++) begin
      rx_line <= f[i];
      repeat (bt) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask
  // wait for a start edge, then sample every bit in its middle
  task automatic catch(input int nb, input int bt, output logic [10:0] f);
    f = '0;
    @(negedge tx_line);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = tx_line;
      repeat (bt) @(posedge clk);
    end
  endtask
  // shift mode receive: new bit at each clock fall, idle high after the last rise
  task automatic send0(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge tx_line);
      rx_line <= d[i];
    end
    @(posedge tx_line);
    rx_line <= 1'b1;
  endtask
  // shift mode: take data at each clock rise, time first to last rise
  task automatic catch0(output logic [7:0] f, output time n);
    time t0;
    t0 = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_line);
      if (i == 0) t0 = $time;
      f[i] = shift_data;
    end
    n = $time - t0;
  endtask
endmodule
`default_nettype wire

// file: sim/serial_port_zero_uart_tb.sv
// self-checking bench for serial port zero
`timescale 1ns/10ps
`default_nettype none
module serial_port_zero_uart_tb;
  import spzu_pkg::*;
  localparam int BT = MODE2_DIV_FAST;  // clocks per bit, fast mode 2 and timer source
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, t1_ovf = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, pin_o, pin_oe, out_pin, irq, rx_line, pin;
  logic [10:0] f;  // captured frame
  logic [7:0]  f0;  // captured shift byte
  time         n;  // shift clock span
  int          err_total = 0, checked = 0, cyc = 0;
  assign pin = pin_oe ? pin_o : rx_line;  // shared receive wire
  always #2.5 clk = ~clk;
  // timer 1 overflow pulse every other clock
  always @(posedge clk) t1_ovf <= ~t1_ovf;
  spzu_top i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .timer1_overflow(t1_ovf),
    .serial_in_pin_i(pin), .serial_in_pin_o(pin_o), .serial_in_pin_oe(pin_oe),
    .serial_out_pin(out_pin), .irq(irq));
  spzu_remote i_remote (.clk(clk), .tx_line(out_pin), .shift_data(pin), .rx_line(rx_line));
  // verdict and end of run
  task automatic end_sim();
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single ahb-lite transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, '0);
    chk(hrdata, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // irq checked two edges after the last register change
  task automatic irqc(input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(IDX_CTRL, 32'h0);
    rdc(8'h10, 32'h0);
    wr(IDX_POWER, 32'h80);
    wr(IDX_IMASK, 32'h3);
    wr(IDX_CTRL, 32'h98);
    fork
      wr(IDX_BUF, 32'ha5);
      i_remote.catch(11, BT, f);
      i_remote.send({2'b11, 8'h3c, 1'b0}, 11, BT);
    join
    chk(f, {2'b11, 8'ha5, 1'b0});
    rdc(IDX_BUF, 32'h3c);
    rdc(IDX_CTRL, 32'h9f);
    irqc(1'b1);
    wr(IDX_IMASK, 32'h0);
    irqc(1'b0);
    wr(IDX_IMASK, 32'h3);
    wr(IDX_ISTAT, 32'h3);
    irqc(1'b0);
    wr(IDX_CTRL, 32'hf0);
    fork
      wr(IDX_BUF, 32'h96);
      i_remote.catch(11, BT, f);
      i_remote.send({2'b10, 8'h11, 1'b0}, 11, BT);
    join
    chk(f, {2'b10, 8'h96, 1'b0});
    rdc(IDX_CTRL, 32'hf2);
    i_remote.send({2'b11, 8'h22, 1'b0}, 11, BT);
    rdc(IDX_CTRL, 32'hf7);
    rdc(IDX_BUF, 32'h22);
    wr(IDX_CTRL, 32'h70);
    fork
      wr(IDX_BUF, 32'h66);
      i_remote.catch(10, BT, f);
      i_remote.send({2'b00, 8'h44, 1'b0}, 10, BT);
    join
    chk(f, {2'b01, 8'h66, 1'b0});
    rdc(IDX_CTRL, 32'h72);
    repeat (64) @(posedge clk);
    i_remote.send({2'b01, 8'h55, 1'b0}, 10, BT);
    rdc(IDX_CTRL, 32'h77);
    rdc(IDX_BUF, 32'h55);
    wr(IDX_CTRL, 32'h00);
    fork
      wr(IDX_BUF, 32'h5a);
      i_remote.catch0(f0, n);
    join
    chk({24'h0, f0}, 32'h5a);
    chk(32'(n), 32'(7 * MODE0_DIV * 5));
    repeat (16) @(posedge clk);
    rdc(IDX_CTRL, 32'h02);
    wr(IDX_CTRL, 32'h10);
    i_remote.send0(8'hc3);
    repeat (16) @(posedge clk);
    rdc(IDX_CTRL, 32'h11);
    rdc(IDX_BUF, 32'hc3);
    end_sim();
  end
endmodule
`default_nettype wire
